// [bench/sec_chk.sv]
// assertions on the ports of the eeprom command byte block
`timescale 1ns/1ps
`default_nettype none
module sec_chk (
   // clock, reset and master engine handshake
   input wire logic mclk, reset_n, ce, eepReq, eepBusy, eepDone,
   // error events, clears and flags
   input wire logic eepNackEvt, eepMssEvt, statusNackClr, statusMssClr,
   input wire logic nackErrorFlag, misplacedStartStopFlag,
   // decoded command and chosen bus address
   input wire logic eepAccessDirection, accessDirection,
   input wire logic useRequestEepromAddr,
   input wire logic [7:0] eepBusAddr, defaultEepromBusAddress,
   // register command claim status
   input wire logic csrReadDone, csrWriteDone, csrFormOk, csrOffsetBad,
   input wire logic readClaimError, writeClaimError
);
   default clocking @(posedge mclk); endclocking
   // a frozen cycle moves no state, so it is not checked
   default disable iff (!reset_n || !ce);
   AST_NACK_SET: assert property (eepNackEvt |=> nackErrorFlag)
      else $error("nack flag not set");
   AST_MSS_SET: assert property (eepMssEvt |=> misplacedStartStopFlag)
      else $error("start stop flag not set");
   AST_NACK_CLR: assert property (statusNackClr && !eepNackEvt
      |=> !nackErrorFlag) else $error("nack flag not cleared");
   AST_MSS_CLR: assert property (statusMssClr && !eepMssEvt
      |=> !misplacedStartStopFlag) else $error("mss flag not cleared");
   AST_REQ_PULSE: assert property (eepReq |-> eepBusy ##1 !eepReq)
      else $error("request not a busy pulse");
   AST_DONE_IDLE: assert property (eepBusy && eepDone |=> !eepBusy)
      else $error("busy after done");
   AST_DIR: assert property (eepReq |->
      eepAccessDirection == accessDirection)
      else $error("wrong access direction");
   AST_DEF_ADDR: assert property (eepReq && !useRequestEepromAddr
      |-> eepBusAddr == defaultEepromBusAddress)
      else $error("bad bus address");
   AST_RD_OK: assert property (csrReadDone && csrFormOk && !csrOffsetBad
      |=> !readClaimError) else $error("read error on good command");
   AST_RD_BAD: assert property (csrReadDone && csrOffsetBad
      |=> readClaimError) else $error("read error missing");
   AST_WR_FORM: assert property (csrWriteDone && !csrFormOk
      |=> writeClaimError) else $error("write error missing");
   AST_WR_BAD: assert property (csrWriteDone && csrOffsetBad
      |=> writeClaimError) else $error("write error on bad offset missing");
endmodule
bind sec_cmd_field sec_chk sec_chk_inst (.mclk(mclk), .reset_n(reset_n),
   .ce(ce), .eepReq(eepReq), .eepBusy(eepBusy), .eepDone(eepDone),
   .eepNackEvt(eepNackEvt), .eepMssEvt(eepMssEvt),
   .statusNackClr(statusNackClr), .statusMssClr(statusMssClr),
   .nackErrorFlag(nackErrorFlag),
   .misplacedStartStopFlag(misplacedStartStopFlag),
   .eepAccessDirection(eepAccessDirection),
   .accessDirection(accessDirection),
   .useRequestEepromAddr(useRequestEepromAddr), .eepBusAddr(eepBusAddr),
   .defaultEepromBusAddress(defaultEepromBusAddress),
   .csrReadDone(csrReadDone), .csrWriteDone(csrWriteDone),
   .csrFormOk(csrFormOk), .csrOffsetBad(csrOffsetBad),
   .readClaimError(readClaimError), .writeClaimError(writeClaimError));
`default_nettype wire

// [bench/sec_host.sv]
// smbus host model driving the slave pins of the command byte block
`timescale 1ns/1ps
`default_nettype none
`include "sec_regs.vh"
module sec_host (
   output logic scl,
   output logic sdaDrv,
   input wire logic sda
);
   // lines idle high; sda relies on the pull-up once released
   initial begin
      scl = 1'b1;
      sdaDrv = 1'b1;
   end
   task automatic start();
      sdaDrv = 1'b1;
      #20 scl = 1'b1;
      #20 sdaDrv = 1'b0;
      #20 scl = 1'b0;
   endtask
   task automatic stop();
      sdaDrv = 1'b0;
      #20 scl = 1'b1;
      #20 sdaDrv = 1'b1;
      #20;
   endtask
   // one 80 ns bit; sda sampled mid high phase
   task automatic clk1(input logic b, output logic s);
      sdaDrv = b;
      #20 scl = 1'b1;
      #20 s = sda;
      #20 scl = 1'b0;
      #20;
   endtask
   task automatic xfer(input logic [7:0] b, input logic ak,
      output logic [7:0] r, output logic a);
      for (int i = 7; i >= 0; i--) clk1(b[i], r[i]);
      clk1(ak, a);
   endtask
   task automatic request(input logic [6:0] sa, input logic [7:0] cmd, ea,
      input logic [15:0] off, input logic [7:0] d, output logic nak);
      logic [7:0] r;
      logic a;
      start();
      xfer({sa, 1'b0}, 1'b1, r, nak);
      xfer(8'h00, 1'b1, r, a);
      xfer(8'h04, 1'b1, r, a);
      xfer(cmd & 8'h2B, 1'b1, r, a);
      xfer({ea[7:1], 1'b0}, 1'b1, r, a);
      xfer(off[7:0], 1'b1, r, a);
      xfer(off[15:8], 1'b1, r, a);
      xfer(d, 1'b1, r, a);
      stop();
   endtask
   task automatic readback(output logic [7:0] rb [6]);
      logic a;
      start();
      xfer({`SEC_SLAVE_ADDR, 1'b1}, 1'b1, rb[0], a);
      for (int i = 0; i < 6; i++) xfer(8'hFF, i == 5, rb[i], a);
      stop();
   endtask
endmodule
`default_nettype wire

// [bench/tb_top.sv]
// self-checking bench for the eeprom command byte block
`timescale 1ns/1ps
`default_nettype none
`include "sec_regs.vh"
module tb_top;
   logic mclk = 1'b0, reset_n = 1'b0, scl, hostSda, eepDone = 0, nak;
   logic eepNackEvt = 0, eepMssEvt = 0, statusNackClr = 0, statusMssClr = 0;
   logic csrReadDone = 0, csrWriteDone = 0, csrFormOk = 0, csrOffsetBad = 0;
   logic [7:0] defaultEepromBusAddress = 8'hA4, eepRdData = 8'h00;
   logic sdaOut, sdaOe, nackErrorFlag, misplacedStartStopFlag, eepReq;
   logic eepAccessDirection, eepBusy, readClaimError, writeClaimError;
   logic accessDirection, useRequestEepromAddr, nackExp = 0, mssExp = 0;
   logic [7:0] eepBusAddr, eepWrData;
   logic [15:0] eepOffset;
   logic ce = 1'b1;
   logic [32:0] expQ [$];
   int error_cnt = 0, comparisons = 0, seed = 51841, cyc = 0;
   // open drain: either side pulling low wins
   wire logic sdaLine = hostSda & ~(sdaOe & ~sdaOut);
   wire logic [32:0] reqSeen = {eepAccessDirection, eepBusAddr, eepOffset,
      eepAccessDirection ? 8'h00 : eepWrData};
   sec_cmd_field sec_cmd_field_inst (.mclk(mclk), .reset_n(reset_n),
      .ce(ce), .sclIn(scl), .sdaIn(sdaLine), .sdaOut(sdaOut),
      .sdaOe(sdaOe), .defaultEepromBusAddress(defaultEepromBusAddress),
      .statusNackClr(statusNackClr), .statusMssClr(statusMssClr),
      .nackErrorFlag(nackErrorFlag),
      .misplacedStartStopFlag(misplacedStartStopFlag), .eepReq(eepReq),
      .eepAccessDirection(eepAccessDirection), .eepBusAddr(eepBusAddr),
      .eepOffset(eepOffset), .eepWrData(eepWrData), .eepBusy(eepBusy),
      .eepDone(eepDone), .eepRdData(eepRdData), .eepNackEvt(eepNackEvt),
      .eepMssEvt(eepMssEvt), .csrReadDone(csrReadDone),
      .csrWriteDone(csrWriteDone), .csrFormOk(csrFormOk),
      .csrOffsetBad(csrOffsetBad), .readClaimError(readClaimError),
      .writeClaimError(writeClaimError), .accessDirection(accessDirection),
      .useRequestEepromAddr(useRequestEepromAddr));
   sec_host sec_host_inst (.scl(scl), .sdaDrv(hostSda), .sda(sdaLine));
   always #2 mclk = ~mclk;
   task automatic check(input logic [39:0] seen, exp);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d errors %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 40000) begin
         error_cnt++;
         tally_and_finish();
      end
   end
   always @(posedge mclk) if (eepReq === 1'b1)
      check(reqSeen, expQ.pop_front());
   task automatic access(input logic [7:0] cmd, input logic nk, ms);
      logic [7:0] ea, d, rb [6];
      logic [15:0] off;
      ea = 8'($random(seed)) & 8'hFE;
      d = 8'($random(seed));
      off = 16'($random(seed));
      eepRdData = 8'($random(seed));
      expQ.push_back({cmd[0], cmd[1] ? ea : defaultEepromBusAddress, off,
         cmd[0] ? 8'h00 : d});
      sec_host_inst.request(`SEC_SLAVE_ADDR, cmd, ea, off, d, nak);
      check(nak, 1'b0);
      check({useRequestEepromAddr, accessDirection}, cmd[1:0]);
      if (cmd[3]) nackExp = 1'b0;
      if (cmd[5]) mssExp = 1'b0;
      for (int k = 0; k < 50 && eepBusy !== 1'b1; k++) @(posedge mclk) #1;
      check(eepBusy, 1'b1);
      {eepNackEvt, eepMssEvt, eepDone} = {nk, ms, 1'b1};
      @(posedge mclk) #1;
      {eepNackEvt, eepMssEvt, eepDone} = 3'b000;
      nackExp |= nk;
      mssExp |= ms;
      @(posedge mclk) #1;
      check(eepBusy, 1'b0);
      sec_host_inst.readback(rb);
      check(rb[0], `SEC_RDBK_COUNT);
      check(rb[1], {2'b00, mssExp, 1'b0, nackExp, 1'b0, cmd[1:0]});
      check({rb[2], rb[4], rb[3]}, {ea, off});
      check(rb[5], cmd[0] ? eepRdData : d);
   endtask
   initial begin
      defaultEepromBusAddress = 8'($random(seed)) & 8'hFE;
      repeat (3) @(posedge mclk);
      #1 reset_n = 1'b1;
      repeat (3) @(posedge mclk);
      #1;
      access(8'h00, 1'b1, 1'b0);
      access(8'h03, 1'b0, 1'b1);
      access(8'h0A, 1'b0, 1'b0);
      access(8'h21, 1'b0, 1'b0);
      // a foreign slave address is left unanswered and starts nothing
      sec_host_inst.request(7'h76, 8'h01, 8'hA0, 16'h0000, 8'h00, nak);
      check(nak, 1'b1);
      // events while frozen must leave both flags clear
      {ce, eepNackEvt, eepMssEvt} = 3'b011;
      @(posedge mclk) #1;
      check({nackErrorFlag, misplacedStartStopFlag}, 2'b00);
      ce = 1'b1;
      @(posedge mclk) #1;
      {eepNackEvt, eepMssEvt} = 2'b00;
      check({nackErrorFlag, misplacedStartStopFlag}, 2'b11);
      {statusNackClr, statusMssClr} = 2'b11;
      @(posedge mclk) #1;
      {statusNackClr, statusMssClr} = 2'b00;
      check({nackErrorFlag, misplacedStartStopFlag}, 2'b00);
      for (int i = 0; i < 8; i++) begin
         {csrFormOk, csrOffsetBad} = {i[0], i[1]};
         {csrReadDone, csrWriteDone} = {!i[2], i[2]};
         @(posedge mclk) #1;
         {csrReadDone, csrWriteDone} = 2'b00;
         @(posedge mclk) #1;
         check(i[2] ? writeClaimError : readClaimError,
            !i[0] | i[1]);
      end
      tally_and_finish();
   end
endmodule
`default_nettype wire

// [include/sec_regs.vh]
// field positions, byte slots and reset values of the eeprom command byte
`ifndef SEC_REGS_VH
`define SEC_REGS_VH

// command byte fields
`define SEC_CMD_DIR_BIT 0
`define SEC_CMD_USA_BIT 1
`define SEC_CMD_NACK_BIT 3
`define SEC_CMD_MSS_BIT 5
`define SEC_DIR_WRITE 1'b0
`define SEC_DIR_READ 1'b1

// byte slots of a block write request after the slave address
`define SEC_POS_COMMAND_CODE_BYTE 3'h0
`define SEC_POS_COUNT 3'h1
`define SEC_POS_CMD 3'h2
`define SEC_POS_EEPROM_BUS_ADDRESS_BYTE 3'h3
`define SEC_POS_OFFLO 3'h4
`define SEC_POS_OFFHI 3'h5
`define SEC_POS_DATA 3'h6
`define SEC_POS_FULL 3'h7

// bytes following the count byte in a block read-back, reset value of a byte and slave address
`define SEC_RDBK_COUNT 8'h05
`define SEC_BYTE_RESET 8'h00
`define SEC_SLAVE_ADDR 7'h77

`endif

// [verilog/sec_cmd_field.v]
// smbus slave that takes eeprom requests and keeps the command byte
`timescale 1ns/1ps
`default_nettype none
`include "sec_regs.vh"
module sec_cmd_field #(
   parameter [6:0] SLAVE_ADDR = `SEC_SLAVE_ADDR
) (
   // clock and reset
   input wire mclk,
   input wire reset_n,
   input wire ce,
   // slave smbus pins
   input wire sclIn,
   input wire sdaIn,
   output wire sdaOut,
   output reg sdaOe,
   // configuration and master status register mirror
   input wire [7:0] defaultEepromBusAddress,
   input wire statusNackClr,
   input wire statusMssClr,
   output reg nackErrorFlag,
   output reg misplacedStartStopFlag,
   // request to the master smbus engine
   output reg eepReq,
   output reg eepAccessDirection,
   output reg [7:0] eepBusAddr,
   output reg [15:0] eepOffset,
   output reg [7:0] eepWrData,
   output reg eepBusy,
   input wire eepDone,
   input wire [7:0] eepRdData,
   input wire eepNackEvt,
   input wire eepMssEvt,
   // register command claim status
   input wire csrReadDone,
   input wire csrWriteDone,
   input wire csrFormOk,
   input wire csrOffsetBad,
   output reg readClaimError,
   output reg writeClaimError,
   // decoded command byte
   output reg accessDirection,
   output reg useRequestEepromAddr
);
   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_ADDR = 3'h1;
   localparam [2:0] ST_WRITE = 3'h2;
   localparam [2:0] ST_READ = 3'h3;
   localparam [2:0] ST_IGNORE = 3'h4;

   wire sclS;
   wire sdaS;
   reg sclD_reg;
   reg sdaD_reg;
   reg [2:0] state_reg;
   reg [3:0] bitCnt_reg;
   reg [7:0] shift_reg;
   reg [2:0] byteIdx_reg;
   reg [2:0] txIdx_reg;
   reg [7:0] eepromBusAddressByte_reg;
   reg [7:0] offLo_reg;
   reg [7:0] offHi_reg;
   reg [7:0] data_reg;

   // the first flop of the synchroniser stays inside sec_sync
   sec_sync #(.WIDTH(2)) uSync (
      .mclk(mclk),
      .reset_n(reset_n),
      .ce(ce),
      .asyncIn({sclIn, sdaIn}),
      .syncOut({sclS, sdaS})
   );
   assign sdaOut = 1'b0;

   wire sclRise = sclS & ~sclD_reg;
   wire sclFall = ~sclS & sclD_reg;
   wire startCond = sclS & sclD_reg & sdaD_reg & ~sdaS;
   wire stopCond = sclS & sclD_reg & ~sdaD_reg & sdaS;

   // current command byte image; reserved bits always read zero
   function [7:0] cmdImage;
      input dir, use_request_eeprom_addr, nack, misplaced_start_stop_flag;
      begin
         cmdImage = 8'h00;
         cmdImage[`SEC_CMD_DIR_BIT] = dir;
         cmdImage[`SEC_CMD_USA_BIT] = use_request_eeprom_addr;
         cmdImage[`SEC_CMD_NACK_BIT] = nack;
         cmdImage[`SEC_CMD_MSS_BIT] = misplaced_start_stop_flag;
      end
   endfunction

   // read-back byte for slot idx of a block read
   function [7:0] txByte;
      input [2:0] idx;
      begin
         case (idx)
            3'h0: txByte = `SEC_RDBK_COUNT;
            3'h1: txByte = cmdImage(accessDirection, useRequestEepromAddr,
               nackErrorFlag, misplacedStartStopFlag);
            3'h2: txByte = eepromBusAddressByte_reg;
            3'h3: txByte = offLo_reg;
            3'h4: txByte = offHi_reg;
            3'h5: txByte = data_reg;
            default: txByte = 8'hFF;
         endcase
      end
   endfunction
   wire [7:0] txCur = txByte(txIdx_reg);
   wire [7:0] txNext = txByte(txIdx_reg + 3'h1);
   wire cmdWrite = (state_reg == ST_WRITE) & sclFall & (bitCnt_reg == 4'h8)
      & (byteIdx_reg == `SEC_POS_CMD);
   // a stop that ends a complete request launches the eeprom access while eepBusy is low
   wire reqComplete = (state_reg == ST_WRITE) & ~eepBusy &
      ((accessDirection == `SEC_DIR_READ) ? (byteIdx_reg >= `SEC_POS_DATA)
                                          : (byteIdx_reg == `SEC_POS_FULL));

   // error flags: a new event wins over a clear in the same cycle
   always @(posedge mclk) begin
      if (!reset_n) begin
         nackErrorFlag <= 1'b0;
         misplacedStartStopFlag <= 1'b0;
      end else if (ce) begin
         if (eepNackEvt)
            nackErrorFlag <= 1'b1;
         else if (statusNackClr ||
                  (cmdWrite && shift_reg[`SEC_CMD_NACK_BIT]))
            nackErrorFlag <= 1'b0;
         if (eepMssEvt)
            misplacedStartStopFlag <= 1'b1;
         else if (statusMssClr ||
                  (cmdWrite && shift_reg[`SEC_CMD_MSS_BIT]))
            misplacedStartStopFlag <= 1'b0;
      end
   end

   // claim status reflects the last register command of each kind
   always @(posedge mclk) begin
      if (!reset_n) begin
         readClaimError <= 1'b0;
         writeClaimError <= 1'b0;
      end else if (ce) begin
         if (csrReadDone)
            readClaimError <= ~csrFormOk | csrOffsetBad;
         if (csrWriteDone)
            writeClaimError <= ~csrFormOk | csrOffsetBad;
      end
   end

   // eeprom request toward the master port
   always @(posedge mclk) begin
      if (!reset_n) begin
         eepReq <= 1'b0;
         eepBusy <= 1'b0;
         eepAccessDirection <= `SEC_DIR_WRITE;
         eepBusAddr <= `SEC_BYTE_RESET;
         eepOffset <= 16'h0000;
         eepWrData <= `SEC_BYTE_RESET;
      end else if (ce) begin
         eepReq <= 1'b0;
         if (stopCond && reqComplete) begin
            eepReq <= 1'b1;
            eepBusy <= 1'b1;
            eepAccessDirection <= accessDirection;
            eepBusAddr <= useRequestEepromAddr ? eepromBusAddressByte_reg
                                               : defaultEepromBusAddress;
            eepOffset <= {offHi_reg, offLo_reg};
            eepWrData <= data_reg;
         end else if (eepDone) begin
            eepBusy <= 1'b0;
         end
      end
   end

   // slave byte engine; no clock stretching, so a matching address and each written byte are acked at once
   always @(posedge mclk) begin
      if (!reset_n) begin
         sclD_reg <= 1'b1;
         sdaD_reg <= 1'b1;
         state_reg <= ST_IDLE;
         bitCnt_reg <= 4'h0;
         shift_reg <= `SEC_BYTE_RESET;
         byteIdx_reg <= 3'h0;
         txIdx_reg <= 3'h0;
         sdaOe <= 1'b0;
         accessDirection <= `SEC_DIR_WRITE;
         useRequestEepromAddr <= 1'b0;
         eepromBusAddressByte_reg <= `SEC_BYTE_RESET;
         offLo_reg <= `SEC_BYTE_RESET;
         offHi_reg <= `SEC_BYTE_RESET;
         data_reg <= `SEC_BYTE_RESET;
      end else if (ce) begin
         sclD_reg <= sclS;
         sdaD_reg <= sdaS;
         if (eepDone && eepAccessDirection == `SEC_DIR_READ)
            data_reg <= eepRdData;
         if (startCond) begin
            state_reg <= ST_ADDR;
            bitCnt_reg <= 4'h0;
            byteIdx_reg <= 3'h0;
            txIdx_reg <= 3'h0;
            sdaOe <= 1'b0;
         end else if (stopCond) begin
            state_reg <= ST_IDLE;
            sdaOe <= 1'b0;
         end else if (state_reg != ST_IDLE && state_reg != ST_IGNORE) begin
            if (sclRise) begin
               if (bitCnt_reg == 4'h8) begin
                  if (state_reg == ST_READ && sdaS)
                     state_reg <= ST_IGNORE;
               end else if (state_reg != ST_READ) begin
                  shift_reg <= {shift_reg[6:0], sdaS};
               end
               bitCnt_reg <= bitCnt_reg + 4'h1;
            end else if (sclFall) begin
               case (state_reg)
                  ST_ADDR: begin
                     if (bitCnt_reg == 4'h8) begin
                        if (shift_reg[7:1] == SLAVE_ADDR)
                           sdaOe <= 1'b1;
                        else
                           state_reg <= ST_IGNORE;
                     end else if (bitCnt_reg == 4'h9) begin
                        bitCnt_reg <= 4'h0;
                        if (shift_reg[0]) begin
                           state_reg <= ST_READ;
                           sdaOe <= ~txCur[7];
                        end else begin
                           state_reg <= ST_WRITE;
                           sdaOe <= 1'b0;
                        end
                     end
                  end
                  ST_WRITE: begin
                     if (bitCnt_reg == 4'h8) begin
                        sdaOe <= 1'b1;
                        case (byteIdx_reg)
                           `SEC_POS_CMD: begin
                              // reserved bits are not stored
                              accessDirection <=
                                 shift_reg[`SEC_CMD_DIR_BIT];
                              useRequestEepromAddr <=
                                 shift_reg[`SEC_CMD_USA_BIT];
                           end
                           `SEC_POS_EEPROM_BUS_ADDRESS_BYTE:
                              eepromBusAddressByte_reg <= shift_reg;
                           `SEC_POS_OFFLO: offLo_reg <= shift_reg;
                           `SEC_POS_OFFHI: offHi_reg <= shift_reg;
                           `SEC_POS_DATA: data_reg <= shift_reg;
                           default: ;
                        endcase
                        if (byteIdx_reg != `SEC_POS_FULL)
                           byteIdx_reg <= byteIdx_reg + 3'h1;
                     end else if (bitCnt_reg == 4'h9) begin
                        sdaOe <= 1'b0;
                        bitCnt_reg <= 4'h0;
                     end
                  end
                  ST_READ: begin
                     if (bitCnt_reg == 4'h8) begin
                        sdaOe <= 1'b0;
                     end else if (bitCnt_reg == 4'h9) begin
                        bitCnt_reg <= 4'h0;
                        txIdx_reg <= txIdx_reg + 3'h1;
                        sdaOe <= ~txNext[7];
                     end else begin
                        sdaOe <= ~txCur[3'h7 - bitCnt_reg[2:0]];
                     end
                  end
                  default: state_reg <= ST_IDLE;
               endcase
            end
         end
      end
   end
endmodule
`default_nettype wire

// [verilog/sec_sync.v]
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module sec_sync #(
   parameter WIDTH = 2
) (
   // clock and reset
   input wire mclk,
   input wire reset_n,
   input wire ce,
   // pins and synchronised levels
   input wire [WIDTH-1:0] asyncIn,
   output reg [WIDTH-1:0] syncOut
);
   reg [WIDTH-1:0] meta_reg;

   // reset value is the idle-high bus level
   always @(posedge mclk) begin
      if (!reset_n) begin
         meta_reg <= {WIDTH{1'b1}};
         syncOut <= {WIDTH{1'b1}};
      end else if (ce) begin
         meta_reg <= asyncIn;
         syncOut <= meta_reg;
      end
   end
endmodule
`default_nettype wire
